// ---- shared/sbsf_pkg.sv ----
// Package of constants and types for the serial buffer status flag block.
package sbsf_pkg;
   localparam int unsigned DATA_W = 16;
   localparam int unsigned SLOTS = 4;
   localparam int unsigned CNT_W = 3;
   localparam int unsigned BITS_PER_WORD = 16;
   localparam logic [11:0] OFF_STATUS_CONTROL = 12'h000;
   localparam logic [11:0] OFF_SHARED_BUF = 12'h004;
   localparam logic [11:0] OFF_IRQ_STATUS = 12'h008;
   localparam logic [11:0] OFF_IRQ_MASK = 12'h00c;
   localparam int unsigned BIT_RBF = 0;
   localparam int unsigned BIT_TBF = 1;
   localparam int unsigned BIT_ENH = 2;
   localparam int unsigned BIT_EN = 3;
   localparam logic [3:0] CTRL_RESET = 4'h0;
   localparam logic [1:0] IRQ_RESET = 2'h0;
   localparam logic [CNT_W-1:0] CNT_RESET = 3'h0;
   localparam logic [4:0] BITCNT_RESET = 5'h00;
   typedef struct packed {
      logic sclk;
      logic sdi;
   } sbsf_link_in_t;
   typedef struct packed {
      logic sdo;
      logic sdo_oe;
   } sbsf_link_out_t;
endpackage

// ---- verilog/sbsf_top.sv ----
// Transmit and receive buffer full flag logic of a serial port, with APB registers and a serial shifter.
//
// Operation
// - Transmit-full reads one until transfer begins
// - Standard mode: buffer write sets transmit-full
// - Standard mode: load into shifter clears it
// - Enhanced: set when last transmit slot fills
// - Enhanced: clear when any transmit slot frees
// - Receive-full reads one while unread data waits
// - Standard mode: shifter copy sets receive-full
// - Standard mode: buffer read clears receive-full
// - Enhanced: set when last receive slot fills
// - Enhanced: clear when any receive slot frees
//
// The implementer's own choices: register access over APB and the address map.
`timescale 1ns/1ps
module sbsf_top (
   input  wire logic                    ref_clk,   // 200 MHz clock
   input  wire logic                    sys_rst,   // Async reset, active high
   input  wire logic                    psel,      // APB select
   input  wire logic                    penable,   // APB enable
   input  wire logic                    pwrite,    // APB direction
   input  wire logic [11:0]             paddr,     // APB byte address
   input  wire logic [31:0]             pwdata,    // APB write data
   output logic      [31:0]             prdata,    // APB read data
   output logic                         pready,    // APB ready
   output logic                         pslverr,   // APB error
   input  wire sbsf_pkg::sbsf_link_in_t link_in,   // Serial clock and data in
   output sbsf_pkg::sbsf_link_out_t     link_out,  // Serial data out
   output logic                         irq        // Level interrupt
);
   localparam int unsigned DW = sbsf_pkg::DATA_W;
   localparam int unsigned CW = sbsf_pkg::CNT_W;
   localparam int unsigned PW = $clog2(sbsf_pkg::SLOTS);
   localparam logic [CW-1:0] FULL_CNT = CW'(sbsf_pkg::SLOTS);
   localparam logic [CW-1:0] ONE_CNT = 3'h1;
   localparam logic [4:0] LAST_BIT = 5'(sbsf_pkg::BITS_PER_WORD - 1);

   // Synchronisers for the link inputs; stage one feeds only stage two.
   logic [1:0] sclk_sync;
   logic [1:0] sdi_sync;
   logic       sclk_prev;
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         sclk_sync <= 2'h0;
         sdi_sync <= 2'h0;
         sclk_prev <= 1'b0;
      end else begin
         sclk_sync <= {sclk_sync[0], link_in.sclk};
         sdi_sync <= {sdi_sync[0], link_in.sdi};
         sclk_prev <= sclk_sync[1];
      end
   end
   wire sclk_rise = sclk_sync[1] & ~sclk_prev;
   wire sclk_fall = ~sclk_sync[1] & sclk_prev;

   // APB decode.
   wire acc = psel & penable;
   wire wr = acc & pwrite;
   wire rd = acc & ~pwrite;
   wire hit_ctrl = (paddr == sbsf_pkg::OFF_STATUS_CONTROL);
   wire hit_buf = (paddr == sbsf_pkg::OFF_SHARED_BUF);
   wire hit_ist = (paddr == sbsf_pkg::OFF_IRQ_STATUS);
   wire hit_msk = (paddr == sbsf_pkg::OFF_IRQ_MASK);
   wire mapped = hit_ctrl | hit_buf | hit_ist | hit_msk;
   wire buf_wr = wr & hit_buf;
   wire buf_rd = rd & hit_buf;
   // Read data is captured in the setup cycle, so it already stands when the access edge takes it.
   wire rd_setup = psel & ~penable & ~pwrite;

   logic enh_mode;
   logic port_en;
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         enh_mode <= sbsf_pkg::CTRL_RESET[sbsf_pkg::BIT_ENH];
         port_en <= sbsf_pkg::CTRL_RESET[sbsf_pkg::BIT_EN];
      end else if (wr & hit_ctrl) begin
         enh_mode <= pwdata[sbsf_pkg::BIT_ENH];
         port_en <= pwdata[sbsf_pkg::BIT_EN];
      end
   end
   // In standard mode one slot is used, so the same storage serves both modes.
   wire [CW-1:0] depth = enh_mode ? FULL_CNT : ONE_CNT;

   // Transmit slots.
   logic [DW-1:0] tx_mem [sbsf_pkg::SLOTS];
   logic [PW-1:0] tx_wp;
   logic [PW-1:0] tx_rp;
   logic [CW-1:0] tx_cnt;
   logic [CW-1:0] next_tx_cnt;
   logic [DW-1:0] shift_register_stage;
   logic [DW-1:0] rx_shift;
   logic [4:0]    bit_cnt;
   logic          busy;

   wire tx_accept = buf_wr & (tx_cnt < depth);
   // The shifter loads a word only between words, so a load always precedes its first bit.
   localparam logic [CW-1:0] CNT_RESET_W = sbsf_pkg::CNT_RESET;
   wire tx_load = port_en & ~busy & (tx_cnt != CNT_RESET_W);
   wire word_done = busy & sclk_rise & (bit_cnt == LAST_BIT);

   always_comb begin
      next_tx_cnt = tx_cnt;
      if (tx_accept & ~tx_load) begin
         next_tx_cnt = tx_cnt + ONE_CNT;
      end else if (tx_load & ~tx_accept) begin
         next_tx_cnt = tx_cnt - ONE_CNT;
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         tx_cnt <= sbsf_pkg::CNT_RESET;
         tx_wp <= '0;
         tx_rp <= '0;
      end else begin
         tx_cnt <= next_tx_cnt;
         if (tx_accept) begin
            tx_wp <= tx_wp + 1'b1;
         end
         if (tx_load) begin
            tx_rp <= tx_rp + 1'b1;
         end
      end
   end
   always_ff @(posedge ref_clk) begin
      if (tx_accept) begin
         tx_mem[tx_wp] <= pwdata[DW-1:0];
      end
   end

   // Full while every available slot holds a word not yet moved into the shifter.
   wire tx_buffer_full_flag = (tx_cnt >= depth);

   // Shifter: data out changes on falling, samples on rising serial clock edges.
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         shift_register_stage <= '0;
         rx_shift <= '0;
         bit_cnt <= sbsf_pkg::BITCNT_RESET;
         busy <= 1'b0;
      end else if (tx_load) begin
         shift_register_stage <= tx_mem[tx_rp];
         bit_cnt <= sbsf_pkg::BITCNT_RESET;
         busy <= 1'b1;
      end else if (busy & sclk_rise) begin
         rx_shift <= {rx_shift[DW-2:0], sdi_sync[1]};
         bit_cnt <= bit_cnt + 5'h01;
         busy <= ~word_done;
      end else if (busy & sclk_fall & (bit_cnt != sbsf_pkg::BITCNT_RESET)) begin
         shift_register_stage <= {shift_register_stage[DW-2:0], 1'b0};
      end
   end
   always_comb begin
      link_out.sdo = shift_register_stage[DW-1];
      link_out.sdo_oe = busy;
   end

   // Receive slots.
   logic [DW-1:0] rx_mem [sbsf_pkg::SLOTS];
   logic [PW-1:0] rx_wp;
   logic [PW-1:0] rx_rp;
   logic [CW-1:0] rx_cnt;
   logic [CW-1:0] next_rx_cnt;
   logic          rx_ovf;
   wire [DW-1:0]  rx_word = {rx_shift[DW-2:0], sdi_sync[1]};
   wire rx_push = word_done & (rx_cnt < depth);
   // A buffer read pops only the word that it showed in its setup cycle; a word that lands between
   // setup and access stays for the next read instead of being popped unseen.
   logic          rd_armed;
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rd_armed <= 1'b0;
      end else if (rd_setup) begin
         rd_armed <= hit_buf & (rx_cnt != CNT_RESET_W);
      end else if (acc) begin
         rd_armed <= 1'b0;
      end
   end
   wire rx_pop = buf_rd & rd_armed;

   always_comb begin
      next_rx_cnt = rx_cnt;
      if (rx_push & ~rx_pop) begin
         next_rx_cnt = rx_cnt + ONE_CNT;
      end else if (rx_pop & ~rx_push) begin
         next_rx_cnt = rx_cnt - ONE_CNT;
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rx_cnt <= sbsf_pkg::CNT_RESET;
         rx_wp <= '0;
         rx_rp <= '0;
      end else begin
         rx_cnt <= next_rx_cnt;
         if (rx_push) begin
            rx_wp <= rx_wp + 1'b1;
         end
         if (rx_pop) begin
            rx_rp <= rx_rp + 1'b1;
         end
      end
   end
   always_ff @(posedge ref_clk) begin
      if (rx_push) begin
         rx_mem[rx_wp] <= rx_word;
      end
   end
   assign rx_ovf = word_done & ~rx_push;

   // Full once every available slot holds an unread word.
   wire rx_buffer_full_flag = (rx_cnt >= depth);

   // Interrupts: bit 0 word received, bit 1 receive overflow; set wins over clear.
   logic [1:0] irq_stat;
   logic [1:0] irq_mask;
   wire  [1:0] irq_evt = {rx_ovf, rx_push};
   wire  [1:0] irq_clr = (wr & hit_ist) ? pwdata[1:0] : 2'h0;
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         irq_stat <= sbsf_pkg::IRQ_RESET;
         irq_mask <= sbsf_pkg::IRQ_RESET;
      end else begin
         irq_stat <= (irq_stat & ~irq_clr) | irq_evt;
         if (wr & hit_msk) begin
            irq_mask <= pwdata[1:0];
         end
      end
   end
   assign irq = |(irq_stat & irq_mask);

   // Read data mux; the receive slot is read combinationally and registered into prdata.
   wire [31:0] ctrl_word = {28'h0000000, port_en, enh_mode, tx_buffer_full_flag, rx_buffer_full_flag};
   // An empty receive side reads as zero, and the stale slot is never shown.
   wire [31:0] buf_word = (rx_cnt != CNT_RESET_W) ? {16'h0000, rx_mem[rx_rp]} : 32'h00000000;
   wire [31:0] rd_mux = hit_ctrl ? ctrl_word :
                        hit_buf  ? buf_word :
                        hit_ist  ? {30'h0, irq_stat} :
                        hit_msk  ? {30'h0, irq_mask} : 32'h00000000;
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         prdata <= 32'h00000000;
      end else if (rd_setup) begin
         prdata <= rd_mux;
      end
   end
   // The slave never stalls: prdata was loaded at the setup edge, so it is valid at the access edge.
   // The flags shown are therefore those of one cycle before the access, which software cannot see.
   assign pready = 1'b1;
   assign pslverr = acc & ~mapped;

   a_tbf_set_std: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (!enh_mode && tx_accept && !tx_load) |=> tx_buffer_full_flag)
      else $error("transmit-full not set after buffer write");
   a_tbf_clr_std: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (!enh_mode && tx_load && !tx_accept && !$past(enh_mode)) |=> !tx_buffer_full_flag)
      else $error("transmit-full not cleared on shifter load");
   a_tbf_enh_level: assert property (@(posedge ref_clk) disable iff (sys_rst)
      enh_mode |-> (tx_buffer_full_flag == (tx_cnt == FULL_CNT)))
      else $error("enhanced transmit-full mismatch");
   a_tbf_enh_free: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (enh_mode && tx_buffer_full_flag && tx_load && !tx_accept) ##1 enh_mode |-> !tx_buffer_full_flag)
      else $error("transmit-full held with a free slot");
   a_rbf_set_std: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (!enh_mode && rx_push && !rx_pop) |=> rx_buffer_full_flag)
      else $error("receive-full not set after word");
   a_rbf_clr_std: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (!enh_mode && rx_pop && !rx_push) ##1 !enh_mode |-> !rx_buffer_full_flag)
      else $error("receive-full not cleared by read");
   a_rbf_enh_fill: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (enh_mode && rx_cnt == FULL_CNT - ONE_CNT && rx_push && !rx_pop) ##1 enh_mode |-> rx_buffer_full_flag)
      else $error("receive-full not set on last slot");
   a_rbf_enh_free: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (enh_mode && rx_buffer_full_flag && rx_pop) ##1 enh_mode |-> !rx_buffer_full_flag)
      else $error("receive-full held with a free slot");
   a_cnt_bound: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (tx_cnt <= FULL_CNT) && (rx_cnt <= FULL_CNT))
      else $error("occupancy counter out of range");
   a_flag_levels: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (!enh_mode && tx_cnt == CNT_RESET_W) |-> (!tx_buffer_full_flag ##0 (rx_cnt != CNT_RESET_W || !rx_buffer_full_flag)))
      else $error("flag shown with empty buffer");

   // A pop must never take a slot that holds no word.
   a_pop_needs_word: assert property (@(posedge ref_clk) disable iff (sys_rst)
      rx_pop |-> (rx_cnt != CNT_RESET_W))
      else $error("receive pop from empty buffer");

   // Each accepted write occupies exactly one more transmit slot.
   a_tx_cnt_up: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (tx_accept && !tx_load) |=> (tx_cnt == $past(tx_cnt) + ONE_CNT))
      else $error("transmit count did not rise");

   // Each load into the shifter frees exactly one transmit slot.
   a_tx_cnt_down: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (tx_load && !tx_accept) |=> (tx_cnt == $past(tx_cnt) - ONE_CNT))
      else $error("transmit count did not fall");

   // Each stored word occupies exactly one more receive slot.
   a_rx_cnt_up: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (rx_push && !rx_pop) |=> (rx_cnt == $past(rx_cnt) + ONE_CNT))
      else $error("receive count did not rise");

   // Each read of a waiting word frees exactly one receive slot.
   a_rx_cnt_down: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (rx_pop && !rx_push) |=> (rx_cnt == $past(rx_cnt) - ONE_CNT))
      else $error("receive count did not fall");

   // A write while full is dropped, so the occupancy must not move.
   a_full_write_drop: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (buf_wr && tx_buffer_full_flag && !tx_load) |=> (tx_cnt == $past(tx_cnt)))
      else $error("write accepted while transmit full");

   // Status bits must be set by their events even when software clears them in the same cycle.
   a_evt_sets_stat: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (irq_evt != 2'h0) |=> ((irq_stat & $past(irq_evt)) == $past(irq_evt)))
      else $error("interrupt event lost");

   // The shifter never counts past the last bit of a word.
   a_shift_count: assert property (@(posedge ref_clk) disable iff (sys_rst)
      busy |-> (bit_cnt <= LAST_BIT))
      else $error("bit counter out of range");

   // A load starts a fresh word in the shifter.
   a_load_starts: assert property (@(posedge ref_clk) disable iff (sys_rst)
      tx_load |=> (busy && bit_cnt == sbsf_pkg::BITCNT_RESET))
      else $error("load did not start a word");

   // In standard mode any unread word shows as receive-full.
   a_rbf_std_level: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (!enh_mode && rx_cnt != CNT_RESET_W) |-> rx_buffer_full_flag)
      else $error("receive-full clear with word waiting");
endmodule

// ---- testbench/sbsf_link_model.sv ----
// Behavioural serial master that clocks words into and out of the port.
`timescale 1ns/1ps
module sbsf_link_model (
   output sbsf_pkg::sbsf_link_in_t       link_in,   // Serial clock and data to the port
   input  wire sbsf_pkg::sbsf_link_out_t link_out   // Serial data from the port
);
   initial begin
      link_in.sclk = 1'b0;
      link_in.sdi  = 1'b1;
   end
   // The clock stands still between frames; data then shows the inverse of the last bit so nothing stale passes.
   task automatic frame(input logic [15:0] word, output logic [15:0] seen);
      // Keeps every link edge off the system clock's sampling edge.
      #1.25;
      for (int i = 15; i >= 0; i--) begin
         link_in.sclk = 1'b0;
         link_in.sdi  = word[i];
         #32;
         link_in.sclk = 1'b1;
         seen[i]      = link_out.sdo;
         #32;
      end
      link_in.sclk = 1'b0;
      link_in.sdi  = ~word[0];
   endtask
endmodule

// ---- testbench/test_spi_buffer_status_flags.sv ----
// Self-checking testbench for the serial buffer status flag block.
`timescale 1ns/1ps
module test_spi_buffer_status_flags;
   logic                     ref_clk, sys_rst, psel, penable, pwrite, pready, pslverr, irq, e;
   logic [11:0]              paddr;
   logic [31:0]              pwdata, prdata, q;
   logic [15:0]              tx [4], rx [4], got;
   sbsf_pkg::sbsf_link_in_t  link_in;
   sbsf_pkg::sbsf_link_out_t link_out;
   int                       fails, checks;
   localparam logic [11:0]   ST = sbsf_pkg::OFF_STATUS_CONTROL;
   localparam logic [11:0]   BF = sbsf_pkg::OFF_SHARED_BUF;

   sbsf_top dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .link_in(link_in), .link_out(link_out), .irq(irq));
   sbsf_link_model lm (.link_in(link_in), .link_out(link_out));

   task automatic tally_and_finish();
      if (fails == 0 && checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic cmp(string what, logic [31:0] exp, logic [31:0] seen);
      checks++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // The slave answers at once; read data and error are taken at the access edge.
   task automatic apb(logic wr, logic [11:0] a, logic [31:0] d, output logic [31:0] rd, output logic err);
      int n;
      @(posedge ref_clk);
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         fails++;
         tally_and_finish();
      end
      err = pslverr;
      rd = prdata;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
   endtask
   task automatic wr(logic [11:0] a, logic [31:0] d);
      apb(1'b1, a, d, q, e);
   endtask
   // Reads until the masked value matches or the tries run out, then compares.
   task automatic rchk(string what, logic [11:0] a, logic [31:0] m, logic [31:0] exp, int tries);
      for (int t = 0; t < tries; t++) begin
         apb(1'b0, a, 32'h0, q, e);
         if ((q & m) === exp) break;
      end
      cmp(what, exp, q & m);
   endtask

   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end
   initial begin
      #400000;
      fails++;
      tally_and_finish();
   end
   initial begin
      sys_rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      fails = 0;
      checks = 0;
      void'($urandom(32'ha9790ede));
      repeat (6) @(posedge ref_clk);
      sys_rst <= 1'b0;
      rchk("status after reset", ST, 32'hf, 32'h0, 1);
      cmp("irq after reset", 32'h0, {31'h0, irq});
      wr(sbsf_pkg::OFF_IRQ_MASK, 32'h1);
      tx[0] = 16'($urandom);
      rx[0] = 16'($urandom);
      wr(BF, {16'h0, tx[0]});
      rchk("tbf on write", ST, 32'h2, 32'h2, 1);
      wr(ST, 32'h8);
      rchk("tbf on load", ST, 32'h2, 32'h0, 8);
      lm.frame(rx[0], got);
      cmp("word shifted out", {16'h0, tx[0]}, {16'h0, got});
      rchk("rbf on receive", ST, 32'h1, 32'h1, 8);
      cmp("irq raised", 32'h1, {31'h0, irq});
      rchk("received word", BF, 32'hffff, {16'h0, rx[0]}, 1);
      rchk("rbf after read", ST, 32'h1, 32'h0, 1);
      wr(sbsf_pkg::OFF_IRQ_STATUS, 32'h1);
      cmp("irq cleared", 32'h0, {31'h0, irq});
      wr(sbsf_pkg::OFF_IRQ_MASK, 32'h0);
      apb(1'b0, 12'h010, 32'h0, q, e);
      cmp("unmapped error", 32'h1, {31'h0, e});
      cmp("unmapped data", 32'h0, q);
      wr(ST, 32'h4);
      for (int i = 0; i < 4; i++) begin
         tx[i] = 16'($urandom);
         wr(BF, {16'h0, tx[i]});
         rchk("tbf enhanced fill", ST, 32'h2, (i == 3) ? 32'h2 : 32'h0, 1);
      end
      wr(ST, 32'hc);
      rchk("tbf enhanced free", ST, 32'h2, 32'h0, 8);
      for (int i = 0; i < 4; i++) begin
         rx[i] = 16'($urandom);
         lm.frame(rx[i], got);
         cmp("enhanced word out", {16'h0, tx[i]}, {16'h0, got});
         rchk("rbf enhanced fill", ST, 32'h1, (i == 3) ? 32'h1 : 32'h0, 8);
      end
      cmp("irq masked", 32'h0, {31'h0, irq});
      for (int i = 0; i < 4; i++) begin
         rchk("enhanced word in", BF, 32'hffff, {16'h0, rx[i]}, 1);
         rchk("rbf enhanced free", ST, 32'h1, 32'h0, 1);
      end
      wr(ST, 32'h8);
      wr(sbsf_pkg::OFF_IRQ_MASK, 32'h2);
      for (int i = 0; i < 2; i++) begin
         tx[i] = 16'($urandom);
         rx[i] = 16'($urandom);
         wr(BF, {16'h0, tx[i]});
         rchk("tbf before frame", ST, 32'h2, 32'h0, 8);
         lm.frame(rx[i], got);
         cmp("standard word out", {16'h0, tx[i]}, {16'h0, got});
      end
      rchk("rbf kept on overflow", ST, 32'h1, 32'h1, 8);
      cmp("irq on overflow", 32'h1, {31'h0, irq});
      rchk("irq status", sbsf_pkg::OFF_IRQ_STATUS, 32'h3, 32'h3, 1);
      rchk("first word kept", BF, 32'hffff, {16'h0, rx[0]}, 1);
      wr(sbsf_pkg::OFF_IRQ_STATUS, 32'h3);
      rchk("irq status cleared", sbsf_pkg::OFF_IRQ_STATUS, 32'h3, 32'h0, 1);
      cmp("irq after clear", 32'h0, {31'h0, irq});
      tally_and_finish();
   end
endmodule
